// ===== fipq_top.sv
`timescale 1ns/1ps
module fipq_top
  import fipq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Incoming interrupt requests
  input  wire logic              reqValid,
  input  wire fipq_req_s         reqInfo,
  output logic                   reqAccepted,
  output logic                   reqRejected,
  // Processor core
  input  wire logic              coreReady,
  input  wire logic              coreIntEnable,
  output fipq_msg_s              dispatchOut,
  output fipq_bypass_s           bypassOut,
  // Broadcast to I/O controllers
  output fipq_msg_s              endMsgOut,
  // Status
  output logic      [7:0]        procPriority,
  output logic      [7:0]        arbPriority
);

  localparam logic [NUM_VEC-1:0] VEC_LSB = {{(NUM_VEC-1){1'b0}}, 1'b1};

  logic [7:0]         taskPri_reg;
  logic [31:0]        ctrl_reg;
  logic [NUM_VEC-1:0] pend_reg;
  logic [NUM_VEC-1:0] inSvc_reg;
  logic [NUM_VEC-1:0] trig_reg;
  logic [31:0]        readdata_reg;
  logic               waitReq_reg;
  logic               reqAccepted_reg;
  logic               reqRejected_reg;
  fipq_msg_s          dispatch_reg;
  fipq_bypass_s       bypass_reg;
  fipq_msg_s          endMsg_reg;
  logic [7:0]         procPri_reg;
  logic [7:0]         arbPri_reg;

  logic               pendFound;
  logic [7:0]         pendTop;
  logic               svcFound;
  logic [7:0]         svcTop;
  logic [7:0]         topSvcVec;
  logic [7:0]         procPri_next;
  logic [7:0]         arbPri_next;
  logic [7:0]         arbRef;
  logic [NUM_CLASS-1:0] classFull;
  logic               eligible;
  logic               promote;
  logic               busTake;
  logic               busDone;
  logic               retire;
  logic               isFixed;
  logic               reqIllegal;
  logic               limitHit;
  logic               accept;
  logic               reject;
  logic [NUM_VEC-1:0] acceptMask;
  logic [NUM_VEC-1:0] promoteMask;
  logic [NUM_VEC-1:0] retireMask;
  logic [2:0]         wordSel;
  logic [31:0]        readMux;

  fipq_prio_enc #(
    .WIDTH    (NUM_VEC),
    .IDX_W    (VEC_W),
    .LOW_SKIP (RESERVED_VECS)
  ) u_pend_enc (
    .bits  (pend_reg),
    .found (pendFound),
    .index (pendTop)
  );

  fipq_prio_enc #(
    .WIDTH    (NUM_VEC),
    .IDX_W    (VEC_W),
    .LOW_SKIP (RESERVED_VECS)
  ) u_svc_enc (
    .bits  (inSvc_reg),
    .found (svcFound),
    .index (svcTop)
  );

  fipq_class_occupancy #(
    .NUM_CLASS  (NUM_CLASS),
    .CLASS_SIZE (CLASS_SIZE),
    .LIMIT      (CLASS_LIMIT)
  ) u_occupancy (
    .occupied  (pend_reg | inSvc_reg),
    .classFull (classFull)
  );

  // Priority computation
  always_comb begin
    topSvcVec = svcFound ? svcTop : NO_VECTOR;
    if (taskPri_reg[7:4] >= topSvcVec[7:4]) begin
      procPri_next = taskPri_reg;
    end else begin
      procPri_next = {topSvcVec[7:4], 4'h0};
    end
    arbRef = (pendFound && pendTop > topSvcVec) ? pendTop : topSvcVec;
    if (taskPri_reg[7:4] >= arbRef[7:4]) begin
      arbPri_next = taskPri_reg;
    end else begin
      arbPri_next = {arbRef[7:4], 4'h0};
    end
  end

  // Dispatch decision; the class test also covers preemption
  assign eligible    = pendFound && (pendTop[7:4] > procPri_next[7:4]);
  assign promote     = eligible && coreReady && coreIntEnable;
  assign promoteMask = promote ? (VEC_LSB << pendTop) : '0;

  // Bus handshake
  assign busTake = (read || write) && waitReq_reg;
  assign busDone = write && !waitReq_reg;
  assign retire  = busDone && (address == OFS_DONE) && svcFound;
  assign retireMask = retire ? (VEC_LSB << svcTop) : '0;

  // Request classification
  always_comb begin
    isFixed    = (reqInfo.mode == MODE_FIXED) || (reqInfo.mode == MODE_LOWEST);
    reqIllegal = (reqInfo.vector[7:4] < MIN_USER_CLASS);
    limitHit   = ctrl_reg[CTRL_LIMIT_BIT] && classFull[reqInfo.vector[7:4]]
                 && !pend_reg[reqInfo.vector];
    accept     = reqValid && isFixed && !reqIllegal && !limitHit;
    reject     = reqValid && isFixed && !accept;
    acceptMask = accept ? (VEC_LSB << reqInfo.vector) : '0;
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      taskPri_reg <= TASK_RST;
      ctrl_reg    <= CTRL_RST;
    end else if (busDone && byteenable[0]) begin
      if (address == OFS_TASK) begin
        taskPri_reg <= writedata[7:0];
      end
      if (address == OFS_CTRL) begin
        ctrl_reg <= {31'h00000000, writedata[CTRL_LIMIT_BIT]};
      end
    end
  end

  // Pending bits: a new request beats a same-cycle promotion
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~promoteMask) | acceptMask;
    end
  end

  // In-service bits
  always_ff @(posedge clk) begin
    if (reset) begin
      inSvc_reg <= '0;
    end else begin
      inSvc_reg <= (inSvc_reg & ~retireMask) | promoteMask;
    end
  end

  // Trigger mode bits
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_reg <= '0;
    end else if (accept) begin
      trig_reg[reqInfo.vector] <= reqInfo.level;
    end
  end

  // Request answers and bypass path
  always_ff @(posedge clk) begin
    if (reset) begin
      reqAccepted_reg <= 1'b0;
      reqRejected_reg <= 1'b0;
      bypass_reg      <= '0;
    end else begin
      reqAccepted_reg   <= accept;
      reqRejected_reg   <= reject;
      bypass_reg.valid  <= reqValid && !isFixed;
      bypass_reg.mode   <= reqInfo.mode;
      bypass_reg.vector <= reqInfo.vector;
    end
  end

  // Core dispatch
  always_ff @(posedge clk) begin
    if (reset) begin
      dispatch_reg <= '0;
    end else begin
      dispatch_reg.valid  <= promote;
      dispatch_reg.vector <= promote ? pendTop : dispatch_reg.vector;
    end
  end

  // End message for level-triggered retirement
  always_ff @(posedge clk) begin
    if (reset) begin
      endMsg_reg <= '0;
    end else begin
      endMsg_reg.valid  <= retire && trig_reg[svcTop];
      endMsg_reg.vector <= retire ? svcTop : endMsg_reg.vector;
    end
  end

  // Priority status
  always_ff @(posedge clk) begin
    if (reset) begin
      procPri_reg <= TASK_RST;
      arbPri_reg  <= TASK_RST;
    end else begin
      procPri_reg <= procPri_next;
      arbPri_reg  <= arbPri_next;
    end
  end

  // Read multiplexer
  always_comb begin
    wordSel = address[4:2];
    readMux = 32'h00000000;
    if (address[ADDR_W-1:ARRAY_LSB] == OFS_PEND[ADDR_W-1:ARRAY_LSB]) begin
      readMux = pend_reg[{wordSel, 5'h00} +: WORD_W];
    end else if (address[ADDR_W-1:ARRAY_LSB] == OFS_INSVC[ADDR_W-1:ARRAY_LSB]) begin
      readMux = inSvc_reg[{wordSel, 5'h00} +: WORD_W];
    end else if (address[ADDR_W-1:ARRAY_LSB] == OFS_TRIG[ADDR_W-1:ARRAY_LSB]) begin
      readMux = trig_reg[{wordSel, 5'h00} +: WORD_W];
    end else begin
      unique case (address)
        OFS_TASK: readMux = {24'h000000, taskPri_reg};
        OFS_PROC: readMux = {24'h000000, procPri_reg};
        OFS_CTRL: readMux = ctrl_reg;
        OFS_ARB:  readMux = {24'h000000, arbPri_reg};
        default:  readMux = 32'h00000000;
      endcase
    end
  end

  // Avalon answer one cycle after the request is seen
  always_ff @(posedge clk) begin
    if (reset) begin
      waitReq_reg  <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      waitReq_reg <= !busTake;
      if (busTake && read) begin
        readdata_reg <= readMux;
      end
    end
  end

  assign readdata     = readdata_reg;
  assign waitrequest  = waitReq_reg;
  assign reqAccepted  = reqAccepted_reg;
  assign reqRejected  = reqRejected_reg;
  assign dispatchOut  = dispatch_reg;
  assign bypassOut    = bypass_reg;
  assign endMsgOut    = endMsg_reg;
  assign procPriority = procPri_reg;
  assign arbPriority  = arbPri_reg;

endmodule // fipq_top

// ===== fipq_pkg.sv
// Summary of operation
// - Class is vector divided by sixteen
// - Fixed requests below class two refused
// - Upper nibble class, lower nibble rank
// - Task priority register readable and writable
// - Deliver only classes above processor priority
// - Arbitration priority from task, pending and in-service
// - Processor priority from task and in-service
// - Top in-service vector, zero when empty
// - Processor priority read-only, gates dispatch
// - Pending and in-service bit vectors kept
// - Bypass modes go straight to core
// - Accepted fixed request sets pending bit
// - Core ready promotes best pending, dispatches
// - Repeat requests merge into pending bit
// - Legacy mode: two per class maximum
// - Higher request preempts without waiting
// - Trigger bit records edge or level
// - Service-done write retires top in-service
// - Level vector retire broadcasts end message
package fipq_pkg;

  localparam int VEC_W          = 8;
  localparam int NUM_VEC        = 256;
  localparam int CLASS_SIZE     = 16;
  localparam int NUM_CLASS      = 16;
  localparam int RESERVED_VECS  = 16;
  localparam int CLASS_LIMIT    = 2;
  localparam int WORD_W         = 32;

  localparam logic [3:0] MIN_USER_CLASS = 4'h2;

  // Register map, byte addresses
  localparam int          ADDR_W      = 10;
  localparam logic [9:0]  OFS_TASK    = 10'h000;
  localparam logic [9:0]  OFS_PROC    = 10'h004;
  localparam logic [9:0]  OFS_DONE    = 10'h008;
  localparam logic [9:0]  OFS_CTRL    = 10'h00C;
  localparam logic [9:0]  OFS_ARB     = 10'h010;
  localparam logic [9:0]  OFS_PEND    = 10'h100;
  localparam logic [9:0]  OFS_INSVC   = 10'h180;
  localparam logic [9:0]  OFS_TRIG    = 10'h200;
  localparam int          ARRAY_LSB   = 5;

  // Field positions and reset values
  localparam int          CTRL_LIMIT_BIT = 0;
  localparam logic [7:0]  TASK_RST       = 8'h00;
  localparam logic [31:0] CTRL_RST       = 32'h00000000;
  localparam logic [7:0]  NO_VECTOR      = 8'h00;

  typedef enum logic [2:0] {
    MODE_FIXED      = 3'h0,
    MODE_LOWEST     = 3'h1,
    MODE_SYS_MGMT   = 3'h2,
    MODE_NMI        = 3'h3,
    MODE_CORE_RESET = 3'h4,
    MODE_LVL_REL    = 3'h5,
    MODE_STARTUP    = 3'h6,
    MODE_EXT_LEGACY = 3'h7
  } fipq_mode_e;

  typedef struct packed {
    logic [7:0] vector;
    fipq_mode_e mode;
    logic       level;
  } fipq_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } fipq_msg_s;

  typedef struct packed {
    logic       valid;
    fipq_mode_e mode;
    logic [7:0] vector;
  } fipq_bypass_s;

endpackage

// ===== fipq_prio_enc.sv
`timescale 1ns/1ps
module fipq_prio_enc #(
  parameter int WIDTH    = 256,
  parameter int IDX_W    = 8,
  parameter int LOW_SKIP = 16
) (
  // Candidate bits
  input  wire logic [WIDTH-1:0] bits,
  // Highest set bit
  output logic                  found,
  output logic [IDX_W-1:0]      index
);

  // Ascending scan: last hit is the highest vector, which ranks highest
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = LOW_SKIP; i < WIDTH; i++) begin
      if (bits[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule // fipq_prio_enc

// ===== fipq_class_occupancy.sv
`timescale 1ns/1ps
module fipq_class_occupancy #(
  parameter int NUM_CLASS  = 16,
  parameter int CLASS_SIZE = 16,
  parameter int LIMIT      = 2
) (
  // Pending or in-service bits
  input  wire logic [NUM_CLASS*CLASS_SIZE-1:0] occupied,
  // Class holds the limit
  output logic      [NUM_CLASS-1:0]            classFull
);

  genvar c;
  generate
    for (c = 0; c < NUM_CLASS; c++) begin : g_class
      logic [5:0] count;
      always_comb begin
        count = 6'h00;
        for (int b = 0; b < CLASS_SIZE; b++) begin
          count = count + 6'(occupied[c*CLASS_SIZE+b]);
        end
        classFull[c] = (count >= 6'(LIMIT));
      end
    end
  endgenerate

endmodule // fipq_class_occupancy

// ===== fipq_top_assertions.sv
`timescale 1ns/1ps
module fipq_checker
  import fipq_pkg::*;
(
  // Clock and bus
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic              waitrequest,
  // Requests
  input wire logic              reqValid,
  input wire fipq_req_s         reqInfo,
  input wire logic              reqAccepted,
  input wire logic              reqRejected,
  // Core side
  input wire logic              coreReady,
  input wire logic              coreIntEnable,
  input wire fipq_msg_s         dispatchOut,
  input wire fipq_bypass_s      bypassOut,
  input wire fipq_msg_s         endMsgOut,
  input wire logic [7:0]        procPriority
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_bus_wait_back: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_low_class_refused: assert property (reqValid && reqInfo.mode <= MODE_LOWEST
    && reqInfo.vector[7:4] < MIN_USER_CLASS |=> reqRejected && !reqAccepted) else $error("low class taken");
  a_bypass_direct: assert property (reqValid && reqInfo.mode > MODE_LOWEST |=> bypassOut.valid
    && bypassOut.vector == $past(reqInfo.vector) && !reqAccepted && !reqRejected) else $error("bypass lost");
  a_dispatch_ready: assert property (dispatchOut.valid |-> $past(coreReady && coreIntEnable)
    && dispatchOut.vector[7:4] >= MIN_USER_CLASS) else $error("dispatch unasked");
  a_nest_higher: assert property (dispatchOut.valid && $past(dispatchOut.valid)
    |-> dispatchOut.vector[7:4] > $past(dispatchOut.vector[7:4])) else $error("nest not higher");
  a_prio_covers: assert property (dispatchOut.valid |=> procPriority[7:4] >= $past(dispatchOut.vector[7:4]))
    else $error("priority below service");
  a_end_cause: assert property (endMsgOut.valid |-> $past(write && !waitrequest && address == OFS_DONE))
    else $error("end message uncaused");
  c_dispatch: cover property (dispatchOut.valid);
  c_end_msg: cover property (endMsgOut.valid);
  c_reject: cover property (reqRejected);
endmodule // fipq_checker

bind fipq_top fipq_checker u_fipq_checker (.clk, .reset, .address, .read, .write, .waitrequest, .reqValid,
  .reqInfo, .reqAccepted, .reqRejected, .coreReady, .coreIntEnable, .dispatchOut, .bypassOut, .endMsgOut,
  .procPriority);

// ===== fipq_core_model.sv
`timescale 1ns/1ps
module fipq_core_model
  import fipq_pkg::*;
(
  // Clock and stall control
  input wire logic       clk,
  input wire logic [1:0] stall,
  // Dispatch in
  input wire fipq_msg_s  dispatchOut,
  // Readiness out
  output logic           coreReady,
  output logic           coreIntEnable
);
  // Handler entry costs a cycle
  always @(posedge clk) begin
    coreReady <= !stall[0] && !dispatchOut.valid;
    coreIntEnable <= !stall[1];
  end
endmodule // fipq_core_model

// ===== tb_fipq_top.sv
`timescale 1ns/1ps
module tb_fipq_top
  import fipq_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, reqValid = 1'b0, mReady = 1'b0, mLim = 1'b0;
  logic waitrequest, reqAccepted, reqRejected, coreReady, coreIntEnable;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = 32'h0, readdata, rd, v;
  logic [1:0] stall = 2'h3;
  logic [7:0] procPriority, arbPriority, mTask = 8'h00, eD[$], gD[$], eE[$], gE[$];
  logic [255:0] mP = '0, mS = '0, mT = '0;
  fipq_req_s reqInfo = '0;
  fipq_msg_s dispatchOut, endMsgOut;
  fipq_bypass_s bypassOut;
  int bad_count = 0, checks_done = 0, seed = 68515;

  fipq_top u_fipq_top (.clk, .reset, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
    .waitrequest, .reqValid, .reqInfo, .reqAccepted, .reqRejected, .coreReady, .coreIntEnable, .dispatchOut,
    .bypassOut, .endMsgOut, .procPriority, .arbPriority);
  fipq_core_model u_fipq_core_model (.clk, .stall, .dispatchOut, .coreReady, .coreIntEnable);

  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (dispatchOut.valid === 1'b1) gD.push_back(dispatchOut.vector);
    if (endMsgOut.valid === 1'b1) gE.push_back(endMsgOut.vector);
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp(string n, ref logic [7:0] e[$], ref logic [7:0] g[$]);
    chk(n, 32'(e.size()), 32'(g.size()));
    foreach (e[i]) if (i < g.size()) chk(n, e[i], g[i]);
    e.delete();
    g.delete();
  endtask

  function automatic int top(logic [255:0] b);
    for (int i = 255; i > 15; i--) if (b[i]) return i;
    return 0;
  endfunction

  function automatic logic [7:0] prio(int s);
    return (mTask[7:4] >= s[7:4]) ? mTask : {s[7:4], 4'h0};
  endfunction

  // Promote best pending while its class beats the current priority
  task automatic promote;
    int p;
    logic [7:0] q;
    forever begin
      p = top(mP);
      q = prio(top(mS));
      if (!mReady || p[7:4] <= q[7:4]) break;
      mP[p] = 1'b0;
      mS[p] = 1'b1;
      eD.push_back(p[7:0]);
    end
  endtask

  task automatic bus(logic w, logic [9:0] a, logic [31:0] d);
    int n;
    int t;
    n = 0;
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      bad_count++;
      final_report();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    t = top(mS);
    if (w && a == OFS_TASK) mTask = d[7:0];
    if (w && a == OFS_CTRL) mLim = d[0];
    if (w && a == OFS_DONE && t != 0) begin
      mS[t] = 1'b0;
      if (mT[t]) eE.push_back(t[7:0]);
    end
    promote();
  endtask

  task automatic send(logic [7:0] vec, fipq_mode_e m, logic lv);
    logic byp, ok;
    byp = m > MODE_LOWEST;
    ok = vec[7:4] >= MIN_USER_CLASS && (!mLim || mP[vec]
      || $countones(mP[{vec[7:4], 4'h0} +: 16] | mS[{vec[7:4], 4'h0} +: 16]) < CLASS_LIMIT);
    reqValid <= 1'b1;
    reqInfo <= '{vec, m, lv};
    @(posedge clk);
    reqValid <= 1'b0;
    @(posedge clk);
    chk("resp", {!byp && ok, !byp && !ok, byp}, {reqAccepted, reqRejected, bypassOut.valid});
    if (byp) chk("bypass", {m, vec}, {bypassOut.mode, bypassOut.vector});
    if (ok && !byp) begin
      mP[vec] = 1'b1;
      mT[vec] = lv;
    end
    promote();
  endtask

  // Two fixed edge requests on consecutive edges, so the later one preempts at once
  task automatic send_pair(logic [7:0] va, logic [7:0] vb);
    reqValid <= 1'b1;
    reqInfo <= '{va, MODE_FIXED, 1'b0};
    @(posedge clk);
    reqInfo <= '{vb, MODE_FIXED, 1'b0};
    @(posedge clk);
    reqValid <= 1'b0;
    chk("resp", 2'b10, {reqAccepted, reqRejected});
    @(posedge clk);
    chk("resp", 2'b10, {reqAccepted, reqRejected});
    mP[va] = 1'b1;
    mT[va] = 1'b0;
    promote();
    mP[vb] = 1'b1;
    mT[vb] = 1'b0;
    promote();
  endtask

  task automatic run(logic [1:0] s);
    stall <= s;
    mReady = (s == 2'h0);
    promote();
    repeat (4) @(posedge clk);
    cmp("dispatch", eD, gD);
    cmp("endmsg", eE, gE);
    chk("ppr", prio(top(mS)), procPriority);
    chk("arbp", prio(top(mP | mS)), arbPriority);
    $display("step done at %0t", $time);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, OFS_TASK, 0);
    chk("task", TASK_RST, rd);
    bus(0, 10'h3F0, 0);
    chk("unmapped", 0, rd);
    v = $random(seed);
    bus(1, OFS_TASK, v);
    bus(0, OFS_TASK, 0);
    chk("task", v[7:0], rd);
    bus(1, OFS_TASK, 32'h50);
    send(8'h20, MODE_FIXED, 0);
    send(8'h6A, MODE_FIXED, 0);
    send(8'h65, MODE_FIXED, 1);
    send(8'h10, MODE_FIXED, 0);
    send(8'h65, MODE_LOWEST, 1);
    bus(0, OFS_PEND + 10'h00C, 0);
    chk("pend", mP[127:96], rd);
    bus(0, OFS_TRIG + 10'h00C, 0);
    chk("trig", mT[127:96], rd);
    bus(1, OFS_PROC, 32'hFF);
    run(2'h0);
    bus(0, OFS_PROC, 0);
    chk("proc", prio(top(mS)), rd);
    bus(0, OFS_ARB, 0);
    chk("arb", prio(top(mP | mS)), rd);
    run(2'h2);
    send(8'h9B, MODE_FIXED, 0);
    run(2'h2);
    run(2'h0);
    repeat (3) begin
      bus(1, OFS_DONE, 0);
      run(2'h0);
    end
    bus(1, OFS_TASK, 0);
    run(2'h0);
    bus(1, OFS_DONE, 0);
    run(2'h0);
    for (int m = 2; m < 8; m++) send(8'($random(seed)), fipq_mode_e'(m), 0);
    run(2'h3);
    bus(1, OFS_CTRL, 1);
    send(8'hA1, MODE_FIXED, 0);
    send(8'hA2, MODE_FIXED, 1);
    send(8'hA3, MODE_FIXED, 0);
    send(8'hA2, MODE_FIXED, 1);
    run(2'h0);
    send_pair(8'hB0, 8'hC0);
    run(2'h0);
    final_report();
  end
endmodule // tb_fipq_top
